// ### bench/scan_host_model.sv
// scan controller model: scan clock, mode select and data in
// assumes one caller at a time; the scan clock rests low between frames
`timescale 1ns/1ps
`default_nettype none
module scan_host_model (
   output logic tck = 1'h0, tms = 1'h0, tdi = 1'h0,
   input wire logic tdo, tdoEnable);
   // 64 ns a bit; tdo read before the rise, a released tdo reads inverted
   task automatic pulse(input logic m, d, output logic o);
      tms <= m;
      tdi <= d;
      #32 o = tdoEnable ? tdo : !tdo;
      tck <= 1'h1;
      #32 tck <= 1'h0;
   endtask
   // idle, capture, n shifts lsb first, update, idle
   task automatic scan(input logic ir, input logic [31:0] din, input int n,
      output logic [31:0] dout);
      logic o;
      dout = 32'h0;
      pulse(1'h1, 1'h0, o);
      if (ir) pulse(1'h1, 1'h0, o);
      repeat (2) pulse(1'h0, 1'h0, o);
      for (int i = 0; i < n; i++) pulse(i == n - 1, din[i], dout[i]);
      pulse(1'h1, 1'h0, o);
      pulse(1'h0, 1'h0, o);
   endtask
endmodule // scan_host_model
`default_nettype wire

// ### bench/scan_port_asserts.sv
// checker beside the scan port block
// assumes a bind to its top module
`timescale 1ns/1ps
`default_nettype none
module scan_port_asserts #(parameter NUM_OUTPUTS = 8) (
   input wire logic mclk, reset, testResetN, tdoEnable, functionalMode, emulatorLine0In,
   input wire logic tck, tdo,
   input wire logic emulatorLine1OutputDisableNIn, emulatorLine0Enable,
   input wire logic crystalOscillatorOutputEnable,
   input wire logic [NUM_OUTPUTS-1:0] coreOutputEnable, pinOutputEnable);
   logic [1:0] up_q;
   // sync stages hold reset values for two cycles, the outputs decoded from them lag for three
   always_ff @(posedge mclk) up_q <= reset ? 2'h0 : up_q + 2'(up_q != 2'h3);
   wire up = up_q == 2'h3;
   wire off = up && !testResetN && emulatorLine0In && !emulatorLine1OutputDisableNIn;
   wire live = up && !off;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   chk_off_pins: assert property (off [*5] |-> pinOutputEnable == '0) else $error("pins on");
   chk_off_xtal: assert property (off [*5] |-> !crystalOscillatorOutputEnable) else $error("xtal");
   chk_off_tdo: assert property (off [*5] |-> !tdoEnable) else $error("tdo on");
   chk_off_emu: assert property (off [*5] |-> !emulatorLine0Enable) else $error("emu on");
   chk_pins_back: assert property (live [*5] |-> pinOutputEnable == $past(coreOutputEnable))
      else $error("pins lag");
   chk_mode: assert property ((up && $stable(testResetN)) [*5] |-> functionalMode != testResetN)
      else $error("mode");
   chk_trst_tdo: assert property ((live && !testResetN) [*5] |-> !tdoEnable) else $error("tdo");
   chk_trst_emu: assert property ((live && !testResetN) [*5] |-> !emulatorLine0Enable)
      else $error("emu");
   chk_tdo_fall: assert property ($changed(tdo) |-> !tck) else $error("tdo moved");
   cover property (off [*5]);
   cover property (live && emulatorLine0Enable);
   cover property ($fell(functionalMode));
endmodule // scan_port_asserts
`default_nettype wire

// ### bench/scan_test_port_output_disable_tb_top.sv
// testbench for the scan port block
// assumes verilog/ on the include path
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_defines.vh"
module scan_test_port_output_disable_tb_top;
   logic mclk = 1'h0, reset = 1'h1, trstN = 1'h0, drv0 = 1'h0, drv1 = 1'h1;
   logic [7:0] core = 8'h5A;
   logic [31:0] rd;
   // test reset, line 0, line 1, then whether outputs must be released
   logic [3:0] rows [8] = '{4'h0, 4'h2, 4'h5, 4'h6, 4'h8, 4'hA, 4'hC, 4'hE};
   int num_errors = 0, checks_done = 0;
   wire tck, tms, tdi, tdo, tdoEn, out0, en0, out1, en1, xtalEn, func, ev0, ev1;
   wire [7:0] pinEn;
   always #2.5 mclk = ~mclk;
   scan_host_model host (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoEnable(tdoEn));
   scan_test_port_output_disable #(.NUM_OUTPUTS(8)) uut (.mclk(mclk), .reset(reset),
      .clkEnable(1'h1), .tck(tck), .tms(tms), .tdi(tdi), .testResetN(trstN), .tdo(tdo),
      .tdoEnable(tdoEn), .emulatorLine0In(en0 ? out0 : drv0), .emulatorLine0Out(out0),
      .emulatorLine0Enable(en0), .emulatorLine1OutputDisableNIn(en1 ? out1 : drv1),
      .emulatorLine1Out(out1), .emulatorLine1Enable(en1), .coreOutputEnable(core),
      .pinOutputEnable(pinEn), .crystalDriveEnable(core[0]), .crystalOscillatorOutputEnable(xtalEn),
      .functionalMode(func), .emulatorEvent0(ev0), .emulatorEvent1(ev1));
   task automatic compare(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      #100000;
      num_errors++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(posedge mclk);
      reset <= 1'h0;
      foreach (rows[i]) begin
         @(posedge mclk) {trstN, drv0, drv1} <= rows[i][3:1];
         core <= ~core;
         repeat (8) @(posedge mclk);
         #1 compare(pinEn, rows[i][0] ? 8'h0 : core);
         compare({xtalEn, func}, {core[0] & !rows[i][0], !trstN});
         compare({ev0, ev1}, {trstN & drv0, trstN & drv1});
      end
      host.pulse(1'h0, 1'h0, rd[0]);
      host.scan(1'h0, 32'h0, 32, rd);
      compare(rd, `ID_WORD);
      host.scan(1'h1, 32'(`INSN_EMUCTRL), 4, rd);
      compare(rd, `IR_CAPTURE);
      host.scan(1'h0, 32'h3, 4, rd);
      compare(rd, `EMU_RESET_VAL);
      #21 compare({en0, out0, en1, out1}, 4'hC);
      @(posedge mclk) trstN <= 1'h0;
      #41 compare({en0, func}, 2'h1);
      report_and_stop();
   end
endmodule // scan_test_port_output_disable_tb_top
bind scan_test_port_output_disable scan_port_asserts #(.NUM_OUTPUTS(NUM_OUTPUTS)) chk (
   .mclk(mclk), .reset(reset), .testResetN(testResetN), .tdoEnable(tdoEnable),
   .tck(tck), .tdo(tdo),
   .functionalMode(functionalMode), .emulatorLine0In(emulatorLine0In),
   .emulatorLine1OutputDisableNIn(emulatorLine1OutputDisableNIn),
   .emulatorLine0Enable(emulatorLine0Enable), .coreOutputEnable(coreOutputEnable),
   .crystalOscillatorOutputEnable(crystalOscillatorOutputEnable),
   .pinOutputEnable(pinOutputEnable));
`default_nettype wire

// ### verilog/scan_port_defines.vh
// scan_port_defines.vh: constants for the scan test port
// assumes inclusion by the scan port block and its bench, by bare name
`ifndef SCAN_PORT_DEFINES_VH
`define SCAN_PORT_DEFINES_VH
// tap states, 1149.1 encoding order
`define TAP_RESET 4'h0
`define TAP_IDLE 4'h1
`define TAP_SEL_DR 4'h2
`define TAP_CAP_DR 4'h3
`define TAP_SHIFT_DR 4'h4
`define TAP_EXIT1_DR 4'h5
`define TAP_PAUSE_DR 4'h6
`define TAP_EXIT2_DR 4'h7
`define TAP_UPD_DR 4'h8
`define TAP_SEL_IR 4'h9
`define TAP_CAP_IR 4'hA
`define TAP_SHIFT_IR 4'hB
`define TAP_EXIT1_IR 4'hC
`define TAP_PAUSE_IR 4'hD
`define TAP_EXIT2_IR 4'hE
`define TAP_UPD_IR 4'hF
// instructions, 4-bit register
`define INSN_BYPASS 4'hF
`define INSN_IDCODE 4'h1
`define INSN_EMUCTRL 4'h2
`define INSN_RESET_VAL 4'h1
`define IR_CAPTURE 4'h1
// emulator control register: [0] line0 drive en, [1] line0 value, [2] line1 en, [3] line1 value
`define EMU_EN0 0
`define EMU_VAL0 1
`define EMU_EN1 2
`define EMU_VAL1 3
`define EMU_RESET_VAL 4'h0
// identity word, value arbitrary
`define ID_WORD 32'h1234_5671
`endif

// ### verilog/scan_test_port_output_disable.v
// scan_test_port_output_disable.v: scan tap with emulator event lines and global output disable
// assumes scan pins arrive asynchronously and scan clock is well below mclk/4
`timescale 1ns/1ps
`default_nettype none
`include "scan_port_defines.vh"
module scan_test_port_output_disable #(
   parameter NUM_OUTPUTS = 8
) (
   // clock and reset
   input wire mclk,
   input wire reset,
   input wire clkEnable,
   // scan pins
   input wire tck,
   input wire tms,
   input wire tdi,
   input wire testResetN,
   output reg tdo,
   output reg tdoEnable,
   // emulator lines
   input wire emulatorLine0In,
   output reg emulatorLine0Out,
   output reg emulatorLine0Enable,
   input wire emulatorLine1OutputDisableNIn,
   output reg emulatorLine1Out,
   output reg emulatorLine1Enable,
   // core outputs and pin enables
   input wire [NUM_OUTPUTS-1:0] coreOutputEnable,
   output reg [NUM_OUTPUTS-1:0] pinOutputEnable,
   input wire crystalDriveEnable,
   output reg crystalOscillatorOutputEnable,
   output reg functionalMode,
   // emulator events seen by the core
   output reg emulatorEvent0,
   output reg emulatorEvent1
);
   // two-flop synchronisers; only the second stage feeds any logic
   reg [5:0] sync1_q;
   reg [5:0] sync2_q;
   reg tckPrev_q;
   wire tckS = sync2_q[0];
   wire tmsS = sync2_q[1];
   wire tdiS = sync2_q[2];
   wire trstS = sync2_q[3];
   wire emu0S = sync2_q[4];
   wire emu1S = sync2_q[5];
   // the scan clock rests low, matching the reset value, so no false edge follows reset
   wire tckRise = tckS & ~tckPrev_q;
   wire tckFall = ~tckS & tckPrev_q;
   // tap state and scan registers
   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [3:0] irShift_q;
   reg [3:0] ir_q;
   reg [31:0] drShift_q;
   reg [3:0] emuCtrl_q;
   // instruction decode; any other code selects the one-bit bypass
   wire selId = (ir_q == `INSN_IDCODE);
   wire selEmu = (ir_q == `INSN_EMUCTRL);
   wire inShiftIr = (state_q == `TAP_SHIFT_IR);
   wire inShiftDr = (state_q == `TAP_SHIFT_DR);
   // decoded on synced levels, so the disable lags the pins by about three cycles
   wire outputsOff = ~trstS & emu0S & ~emu1S;
   // synchronisers, frozen with the rest while the clock enable is low
   always @(posedge mclk) begin
      if (reset) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
         tckPrev_q <= 1'h0;
      end else if (clkEnable) begin
         sync1_q <= {emulatorLine1OutputDisableNIn, emulatorLine0In, testResetN, tdi, tms, tck};
         sync2_q <= sync1_q;
         tckPrev_q <= tckS;
      end
   end
   always @* begin
      state_d = state_q;
      case (state_q)
         `TAP_RESET: state_d = tmsS ? `TAP_RESET : `TAP_IDLE;
         `TAP_IDLE: state_d = tmsS ? `TAP_SEL_DR : `TAP_IDLE;
         `TAP_SEL_DR: state_d = tmsS ? `TAP_SEL_IR : `TAP_CAP_DR;
         `TAP_CAP_DR: state_d = tmsS ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
         `TAP_SHIFT_DR: state_d = tmsS ? `TAP_EXIT1_DR : `TAP_SHIFT_DR;
         `TAP_EXIT1_DR: state_d = tmsS ? `TAP_UPD_DR : `TAP_PAUSE_DR;
         `TAP_PAUSE_DR: state_d = tmsS ? `TAP_EXIT2_DR : `TAP_PAUSE_DR;
         `TAP_EXIT2_DR: state_d = tmsS ? `TAP_UPD_DR : `TAP_SHIFT_DR;
         `TAP_UPD_DR: state_d = tmsS ? `TAP_SEL_DR : `TAP_IDLE;
         `TAP_SEL_IR: state_d = tmsS ? `TAP_RESET : `TAP_CAP_IR;
         `TAP_CAP_IR: state_d = tmsS ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
         `TAP_SHIFT_IR: state_d = tmsS ? `TAP_EXIT1_IR : `TAP_SHIFT_IR;
         `TAP_EXIT1_IR: state_d = tmsS ? `TAP_UPD_IR : `TAP_PAUSE_IR;
         `TAP_PAUSE_IR: state_d = tmsS ? `TAP_EXIT2_IR : `TAP_PAUSE_IR;
         `TAP_EXIT2_IR: state_d = tmsS ? `TAP_UPD_IR : `TAP_SHIFT_IR;
         default: state_d = tmsS ? `TAP_SEL_DR : `TAP_IDLE;
      endcase
   end
   // tap state machine, held in reset while test reset is low
   always @(posedge mclk) begin
      if (reset) begin
         state_q <= `TAP_RESET;
      end else if (clkEnable) begin
         if (!trstS) begin
            state_q <= `TAP_RESET;
         end else if (tckRise) begin
            state_q <= state_d;
         end
      end
   end
   // instruction register
   always @(posedge mclk) begin
      if (reset) begin
         irShift_q <= 4'h0;
         ir_q <= `INSN_RESET_VAL;
      end else if (clkEnable) begin
         if (!trstS) begin
            ir_q <= `INSN_RESET_VAL;
         end else if (tckRise) begin
            case (state_q)
               `TAP_RESET: ir_q <= `INSN_RESET_VAL;
               `TAP_CAP_IR: irShift_q <= `IR_CAPTURE;
               `TAP_SHIFT_IR: irShift_q <= {tdiS, irShift_q[3:1]};
               `TAP_UPD_IR: ir_q <= irShift_q;
               default: ;
            endcase
         end
      end
   end
   // data register; its length follows the selected instruction
   always @(posedge mclk) begin
      if (reset) begin
         drShift_q <= 32'h0000_0000;
      end else if (clkEnable && trstS && tckRise) begin
         if (state_q == `TAP_CAP_DR) begin
            if (selId) begin
               drShift_q <= `ID_WORD;
            end else if (selEmu) begin
               drShift_q <= {28'h000_0000, emuCtrl_q};
            end else begin
               drShift_q <= 32'h0000_0000;
            end
         end else if (inShiftDr) begin
            if (selId) begin
               drShift_q <= {tdiS, drShift_q[31:1]};
            end else if (selEmu) begin
               drShift_q <= {28'h000_0000, tdiS, drShift_q[3:1]};
            end else begin
               drShift_q <= {31'h0000_0000, tdiS};
            end
         end
      end
   end
   // emulator control, loaded at update and cleared by test reset
   always @(posedge mclk) begin
      if (reset) begin
         emuCtrl_q <= `EMU_RESET_VAL;
      end else if (clkEnable) begin
         if (!trstS) begin
            emuCtrl_q <= `EMU_RESET_VAL;
         end else if (tckRise && (state_q == `TAP_UPD_DR) && selEmu) begin
            emuCtrl_q <= drShift_q[3:0];
         end
      end
   end
   // tdo moves only on falls, so the far end samples a settled bit on the rise
   always @(posedge mclk) begin
      if (reset) begin
         tdo <= 1'h0;
         tdoEnable <= 1'h0;
      end else if (clkEnable) begin
         if (outputsOff) begin
            tdoEnable <= 1'h0;
         end else if (!trstS) begin
            tdoEnable <= 1'h0;
         end else if (tckFall) begin
            tdoEnable <= inShiftIr | inShiftDr;
         end
         if (tckFall) begin
            tdo <= inShiftIr ? irShift_q[0] : drShift_q[0];
         end
      end
   end
   // event lines only while test reset is high; the scan sets their direction
   always @(posedge mclk) begin
      if (reset) begin
         emulatorLine0Out <= 1'h0;
         emulatorLine0Enable <= 1'h0;
         emulatorLine1Out <= 1'h0;
         emulatorLine1Enable <= 1'h0;
         emulatorEvent0 <= 1'h0;
         emulatorEvent1 <= 1'h0;
      end else if (clkEnable) begin
         emulatorLine0Enable <= trstS & emuCtrl_q[`EMU_EN0] & ~outputsOff;
         emulatorLine0Out <= emuCtrl_q[`EMU_VAL0];
         emulatorLine1Enable <= trstS & emuCtrl_q[`EMU_EN1] & ~outputsOff;
         emulatorLine1Out <= emuCtrl_q[`EMU_VAL1];
         emulatorEvent0 <= trstS & ~emuCtrl_q[`EMU_EN0] & emu0S;
         emulatorEvent1 <= trstS & ~emuCtrl_q[`EMU_EN1] & emu1S;
      end
   end
   // global output disable; drivers return one cycle after any term drops
   always @(posedge mclk) begin
      if (reset) begin
         pinOutputEnable <= {NUM_OUTPUTS{1'h0}};
         crystalOscillatorOutputEnable <= 1'h0;
         functionalMode <= 1'h1;
      end else if (clkEnable) begin
         if (outputsOff) begin
            pinOutputEnable <= {NUM_OUTPUTS{1'h0}};
            crystalOscillatorOutputEnable <= 1'h0;
         end else begin
            pinOutputEnable <= coreOutputEnable;
            crystalOscillatorOutputEnable <= crystalDriveEnable;
         end
         functionalMode <= ~trstS;
      end
   end
endmodule // scan_test_port_output_disable
`default_nettype wire
